// [rtl/touch_port_pkg.sv]
// Constants shared by the touch sensor serial slave port
package touch_port_pkg;
	localparam logic [6:0] dev_addr         = 7'h1b;
	localparam logic [7:0] ptr_limit        = 8'h80;
	localparam logic [6:0] det_status_addr  = 7'h02;
	localparam logic [6:0] key_status_addr  = 7'h03;
	localparam logic [6:0] ptr_reset        = 7'h00;
	localparam int         max_scl_khz      = 400;
	localparam int         sync_stages      = 3;

	typedef enum logic [2:0] {
		st_idle    = 3'b000,
		st_addr    = 3'b001,
		st_addr_ak = 3'b010,
		st_wr      = 3'b011,
		st_wr_ak   = 3'b100,
		st_rd      = 3'b101,
		st_rd_ak   = 3'b110
	} link_state_e;
endpackage

// [rtl/pin_filter.sv]
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_filter (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic pin,
	output logic      level
);
	typedef struct packed {
		logic [2:0] sh;
		logic       level;
	} filt_s;

	filt_s q;
	filt_s next_q;

	always_comb begin
		next_q = q;
		next_q.sh = {q.sh[1:0], pin};
		if (q.sh[1] == q.sh[2]) begin
			next_q.level = q.sh[2];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '{sh: 3'b111, level: 1'b1};
		end else begin
			q <= next_q;
		end
	end

	assign level = q.level;
endmodule // pin_filter

// [rtl/touch_i2c_slave.sv]
// Serial slave port of the touch sensor, with change line and table access
// Notes on behaviour
// - Port maps onto byte table, multibyte reads and writes.
// - Change line pulled low after any key change since last read.
// - Change line released once both status bytes are read.
// - If status returns before read, line stays low until both status bytes are read.
// - Only fixed address 0x1b answered, not configurable.
// - Address with write bit is acknowledged.
// - Pointer byte acknowledged when 0x00 to 0x7f, else refused.
// - Data bytes acknowledged only after a valid pointer.
// - Written bytes go to consecutive locations, pointer increments.
// - Read setup pointer acknowledged when below 0x80.
// - Read address acknowledged, then byte at current pointer sent.
// - Pointer advances after each byte sent; host ACK sends next byte; NACK stops.
// - After each read, pointer returns to last written pointer.
// - Sixteen-bit values are not latched; each byte read live.
// - Lines only driven low or released.
// - Mode input high disables serial port for standalone use.
// - Status bytes are addresses 2 and 3.
`timescale 1ns/1ps
module touch_i2c_slave #(
	parameter int addr_width  = 7,
	parameter int table_depth = 128
) (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       mode_standalone,
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	output logic            change_out,
	output logic            change_oe,
	input  wire logic       key_event,
	output logic [6:0]      table_addr,
	output logic            table_rd,
	input  wire logic [7:0] table_rdata,
	output logic            table_wr,
	output logic [7:0]      table_wdata
);
	import touch_port_pkg::*;

	// ==========================================================
	// Parameter check
	if (addr_width != 7 || table_depth != int'(ptr_limit)) begin : g_bad_size
		$error("touch_i2c_slave: only a 128-entry table is supported");
	end

	// ==========================================================
	// Pin conditioning
	logic scl_f;
	logic sda_f;
	logic mode_f;

	pin_filter u_scl (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin      (scl_in),
		.level    (scl_f)
	);

	pin_filter u_sda (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin      (sda_in),
		.level    (sda_f)
	);

	pin_filter u_mode (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin      (mode_standalone),
		.level    (mode_f)
	);

	// ==========================================================
	// State
	typedef struct packed {
		link_state_e st;
		logic        scl_d;
		logic        sda_d;
		logic [7:0]  sh;
		logic [3:0]  bitn;
		logic        is_read;
		logic        ptr_phase;
		logic        ptr_ok;
		logic [6:0]  ptr;
		logic [6:0]  base;
		logic        drive_low;
		logic        changed;
		logic        seen_det;
		logic        seen_key;
		logic        any_read;
		logic        rd_req;
		logic        wr_req;
		logic [7:0]  wdata;
		logic        host_ack;
	} port_s;

	port_s q;
	port_s next_q;

	localparam port_s idle_q = '{
		st:        st_idle,
		scl_d:     1'b1,
		sda_d:     1'b1,
		sh:        8'h00,
		bitn:      4'h0,
		is_read:   1'b0,
		ptr_phase: 1'b0,
		ptr_ok:    1'b0,
		ptr:       ptr_reset,
		base:      ptr_reset,
		drive_low: 1'b0,
		changed:   1'b0,
		seen_det:  1'b0,
		seen_key:  1'b0,
		any_read:  1'b0,
		rd_req:    1'b0,
		wr_req:    1'b0,
		wdata:     8'h00,
		host_ack:  1'b0
	};

	// ==========================================================
	// Bus conditions
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	assign scl_rise = scl_f && !q.scl_d;
	assign scl_fall = !scl_f && q.scl_d;
	assign start_c  = scl_f && q.scl_d && q.sda_d && !sda_f;
	assign stop_c   = scl_f && q.scl_d && !q.sda_d && sda_f;

	// ==========================================================
	// Byte decoding
	logic       byte_end;
	logic       addr_hit;
	logic       ptr_valid;
	logic       status_det;
	logic       status_key;
	logic       clear_now;
	logic       first_low;
	logic       next_low;
	logic [3:0] bit_next;
	logic [6:0] ptr_next;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;

	assign byte_end   = scl_fall && q.bitn == 4'h8;
	assign addr_hit   = q.sh[7:1] == dev_addr;
	assign ptr_valid  = q.sh < ptr_limit;
	assign status_det = q.ptr == det_status_addr;
	assign status_key = q.ptr == key_status_addr;
	assign clear_now  = q.any_read && q.seen_det && q.seen_key;
	assign first_low  = !table_rdata[7];
	assign next_low   = !q.sh[6];
	assign bit_next   = q.bitn + 4'h1;
	assign ptr_next   = q.ptr + 7'h1;
	assign rx_shift   = {q.sh[6:0], sda_f};
	assign tx_shift   = {q.sh[6:0], 1'b0};

	// ==========================================================
	// Next state
	always_comb begin
		next_q        = q;
		next_q.scl_d  = scl_f;
		next_q.sda_d  = sda_f;
		next_q.rd_req = 1'b0;
		next_q.wr_req = 1'b0;

		// Change tracking: a new event wins over a clearing read
		if (clear_now) begin
			next_q.changed  = 1'b0;
			next_q.any_read = 1'b0;
			next_q.seen_det = 1'b0;
			next_q.seen_key = 1'b0;
		end
		if (key_event) begin
			next_q.changed  = 1'b1;
			next_q.any_read = 1'b0;
			next_q.seen_det = 1'b0;
			next_q.seen_key = 1'b0;
		end

		// Link state machine
		if (mode_f) begin
			next_q.st        = st_idle;
			next_q.drive_low = 1'b0;
		end else if (start_c) begin
			next_q.st        = st_addr;
			next_q.bitn      = 4'h0;
			next_q.drive_low = 1'b0;
		end else if (stop_c) begin
			next_q.st        = st_idle;
			next_q.drive_low = 1'b0;
			if (q.is_read) begin
				next_q.ptr = q.base;
			end
		end else begin
			case (q.st)
				st_idle: begin
					next_q.drive_low = 1'b0;
				end
				st_addr, st_wr: begin
					if (scl_rise) begin
						next_q.sh   = rx_shift;
						next_q.bitn = bit_next;
					end
					if (byte_end) begin
						if (q.st == st_addr) begin
							if (addr_hit) begin
								next_q.st        = st_addr_ak;
								next_q.drive_low = 1'b1;
								next_q.is_read   = q.sh[0];
								next_q.ptr_phase = !q.sh[0];
								if (q.sh[0]) begin
									next_q.rd_req = 1'b1;
								end
							end else begin
								next_q.st = st_idle;
							end
						end else if (q.ptr_phase) begin
							next_q.st        = st_wr_ak;
							next_q.ptr_phase = 1'b0;
							next_q.ptr_ok    = ptr_valid;
							next_q.drive_low = ptr_valid;
							if (ptr_valid) begin
								next_q.ptr  = q.sh[6:0];
								next_q.base = q.sh[6:0];
							end
						end else begin
							next_q.st        = st_wr_ak;
							next_q.drive_low = q.ptr_ok;
							if (q.ptr_ok) begin
								next_q.wr_req = 1'b1;
								next_q.wdata  = q.sh;
							end
						end
					end
				end
				st_addr_ak, st_wr_ak: begin
					if (q.wr_req) begin
						next_q.ptr = ptr_next;
					end
					if (scl_fall) begin
						next_q.bitn = 4'h0;
						if (q.is_read && q.st == st_addr_ak) begin
							next_q.st        = st_rd;
							next_q.sh        = table_rdata;
							next_q.drive_low = first_low;
						end else begin
							next_q.st        = st_wr;
							next_q.drive_low = 1'b0;
						end
					end
				end
				st_rd: begin
					if (scl_rise) begin
						next_q.bitn = bit_next;
					end
					if (scl_fall) begin
						if (q.bitn == 4'h8) begin
							next_q.st        = st_rd_ak;
							next_q.drive_low = 1'b0;
							next_q.any_read  = 1'b1;
							if (status_det) begin
								next_q.seen_det = 1'b1;
							end
							if (status_key) begin
								next_q.seen_key = 1'b1;
							end
							next_q.ptr = ptr_next;
						end else begin
							next_q.sh        = tx_shift;
							next_q.drive_low = next_low;
						end
					end
				end
				st_rd_ak: begin
					if (scl_rise) begin
						next_q.host_ack = !sda_f;
						if (!sda_f) begin
							next_q.rd_req = 1'b1;
						end
					end
					if (scl_fall) begin
						next_q.bitn = 4'h0;
						if (q.host_ack) begin
							next_q.st        = st_rd;
							next_q.sh        = table_rdata;
							next_q.drive_low = first_low;
						end else begin
							next_q.st  = st_idle;
							next_q.ptr = q.base;
						end
					end
				end
				default: begin
					next_q.st = st_idle;
				end
			endcase
		end
		// A read ending in the same cycle as a new event does not set any_read, but its status byte still counts as seen
		if (key_event) begin
			next_q.any_read = 1'b0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			q <= idle_q;
		end else begin
			q <= next_q;
		end
	end

	// ==========================================================
	// Outputs
	assign scl_out     = 1'b0;
	assign scl_oe      = 1'b0;
	assign sda_out     = 1'b0;
	assign sda_oe      = q.drive_low && !mode_f;
	assign change_out  = 1'b0;
	assign change_oe   = q.changed && !mode_f;

	// ==========================================================
	// Table access
	assign table_addr  = q.ptr;
	assign table_rd    = q.rd_req;
	assign table_wr    = q.wr_req;
	assign table_wdata = q.wdata;
endmodule // touch_i2c_slave

// [tb/touch_port_monitor.sv]
// Checker for the touch sensor serial port
`timescale 1ns/1ps
module touch_port_monitor (
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic       mode_standalone,
	input wire logic       scl_in,
	input wire logic       scl_out,
	input wire logic       scl_oe,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       change_out,
	input wire logic       change_oe,
	input wire logic       key_event,
	input wire logic [6:0] table_addr,
	input wire logic       table_rd,
	input wire logic       table_wr
);
	logic [6:0] wr_at;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			wr_at <= 7'h00;
		else if (table_wr)
			wr_at <= table_addr;
	end
	low_only_a: assert property (!sda_out && !scl_out && !change_out)
		else $error("line driven high");
	no_stretch_a: assert property (!scl_oe)
		else $error("clock line pulled");
	sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data moved while clock high");
	change_set_a: assert property (key_event && !mode_standalone |-> ##[1:4] change_oe)
		else $error("change line not set");
	wr_step_a: assert property (table_wr |-> ##[1:8] table_addr == wr_at + 7'h01)
		else $error("pointer not advanced");
	wr_pulse_a: assert property (table_wr |=> !table_wr)
		else $error("write pulse too long");
	rd_pulse_a: assert property (table_rd |=> !table_rd)
		else $error("read pulse too long");
	alone_quiet_a: assert property (mode_standalone [*8] |-> !sda_oe && !change_oe && !table_wr)
		else $error("port active in standalone");
endmodule // touch_port_monitor
bind touch_i2c_slave touch_port_monitor u_mon (
	.core_clk        (core_clk),
	.resetn          (resetn),
	.mode_standalone (mode_standalone),
	.scl_in          (scl_in),
	.scl_out         (scl_out),
	.scl_oe          (scl_oe),
	.sda_out         (sda_out),
	.sda_oe          (sda_oe),
	.change_out      (change_out),
	.change_oe       (change_oe),
	.key_event       (key_event),
	.table_addr      (table_addr),
	.table_rd        (table_rd),
	.table_wr        (table_wr)
);

// [tb/i2c_host.sv]
// Host controller model driving the serial bus
`timescale 1ns/1ps
module i2c_host (
	input wire logic core_clk,
	input wire logic sda,
	output logic     scl_oe,
	output logic     sda_oe
);
	initial begin
		scl_oe = 0;
		sda_oe = 0;
	end
	task automatic wt(int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic start();
		sda_oe = 0;
		wt(60);
		scl_oe = 0;
		wt(60);
		sda_oe = 1;
		wt(60);
		scl_oe = 1;
		wt(60);
	endtask
	task automatic stop();
		sda_oe = 1;
		wt(63);
		scl_oe = 0;
		wt(63);
		sda_oe = 0;
		wt(63);
	endtask
	task automatic bitx(input logic b, output logic r);
		sda_oe = !b;
		wt(62);
		scl_oe = 0;
		wt(62);
		r = sda;
		wt(63);
		scl_oe = 1;
		wt(63);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(ak, a);
	endtask
endmodule // i2c_host

// [tb/testbench.sv]
// Self-checking testbench for the touch sensor serial port
`timescale 1ns/1ps
module testbench;
	import touch_port_pkg::*;
	logic core_clk, resetn, mode_standalone, key_event, h_scl, h_sda, a;
	logic scl_out, scl_oe, sda_out, sda_oe, change_out, change_oe, table_rd, table_wr;
	logic [6:0] table_addr;
	logic [7:0] table_wdata, q, mem [128];
	int num_errors, checked;
	wire scl_in = !(h_scl | scl_oe);
	wire sda_in = !(h_sda | sda_oe);
	wire [7:0] table_rdata = mem[table_addr];
	touch_i2c_slave uut (.*);
	i2c_host host (.core_clk(core_clk), .sda(sda_in), .scl_oe(h_scl), .sda_oe(h_sda));
	always @(posedge core_clk)
		if (table_wr)
			mem[table_addr] <= table_wdata;
	function automatic logic [7:0] nak(logic [7:0] p);
		return {7'h00, p >= ptr_limit};
	endfunction
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic sb(logic [7:0] d, logic [7:0] e);
		host.xfer(d, 1'b1, q, a);
		chk("ack", e, {7'h00, a});
	endtask
	task automatic rb(logic [7:0] e, logic hk);
		host.xfer(8'hff, hk, q, a);
		chk("data", e, q);
	endtask
	task automatic pulse();
		@(negedge core_clk) key_event = 1;
		@(negedge core_clk) key_event = 0;
		repeat (6) @(negedge core_clk);
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	initial begin
		#800us;
		num_errors++;
		summarize();
	end
	initial begin
		logic [6:0] p;
		logic [7:0] d [3];
		logic [7:0] x;
		resetn = 0;
		mode_standalone = 0;
		key_event = 0;
		void'($urandom(32'he36ae842));
		foreach (mem[i]) mem[i] = 8'($urandom);
		repeat (8) @(negedge core_clk);
		resetn = 1;
		repeat (8) @(negedge core_clk);
		host.start();
		sb({7'h2a, 1'b0}, 8'h01);
		host.stop();
		p = 7'h20 + 7'($urandom_range(22));
		foreach (d[i]) d[i] = 8'($urandom);
		host.start();
		sb({dev_addr, 1'b0}, 8'h00);
		sb({1'b0, p}, nak({1'b0, p}));
		foreach (d[i]) sb(d[i], 8'h00);
		host.stop();
		foreach (d[i]) chk("mem", d[i], mem[p + i]);
		host.start();
		sb({dev_addr, 1'b0}, 8'h00);
		sb({1'b0, p}, nak({1'b0, p}));
		host.start();
		sb({dev_addr, 1'b1}, 8'h00);
		foreach (d[i]) rb(d[i], i == 2);
		host.stop();
		host.start();
		sb({dev_addr, 1'b1}, 8'h00);
		rb(d[0], 1);
		host.stop();
		x = 8'h80 | 8'($urandom);
		host.start();
		sb({dev_addr, 1'b0}, 8'h00);
		sb(x, nak(x));
		sb(8'h5a, 8'h01);
		host.stop();
		pulse();
		pulse();
		chk("chg", 8'h01, {7'h00, change_oe});
		host.start();
		sb({dev_addr, 1'b0}, 8'h00);
		sb({1'b0, det_status_addr}, 8'h00);
		host.start();
		sb({dev_addr, 1'b1}, 8'h00);
		rb(mem[det_status_addr], 0);
		rb(mem[key_status_addr], 1);
		host.stop();
		repeat (6) @(negedge core_clk);
		chk("chg", 8'h00, {7'h00, change_oe});
		mode_standalone = 1;
		pulse();
		host.start();
		sb({dev_addr, 1'b0}, 8'h01);
		host.stop();
		chk("chg", 8'h00, {7'h00, change_oe});
		summarize();
	end
endmodule // testbench
